// ===== logic/char_channels.sv
// character channels between the exchange logic and the bit engines
`timescale 1ns/10ps
interface tx_char_if;
  logic ctrl; // offered character is control
  logic [7:0] data; // payload, control code in low bits
  logic taken; // pulse: serialiser latched the offer
  modport producer (output ctrl, output data, input taken);
  modport consumer (input ctrl, input data, output taken);
endinterface : tx_char_if

interface rx_char_if;
  logic valid; // pulse: parity-checked character
  logic ctrl; // character is control
  logic [7:0] data; // payload, control code in low bits
  logic parityErr; // pulse: parity check failed
  logic bitEdge; // pulse: transition on data or strobe
  modport producer (output valid, output ctrl, output data, output parityErr, output bitEdge);
  modport consumer (input valid, input ctrl, input data, input parityErr, input bitEdge);
endinterface : rx_char_if

// ===== logic/ds_receiver.sv
// data-strobe deserialiser, holds each character until its parity is known
`timescale 1ns/10ps
module ds_receiver (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic enable, // low clears the receiver
  input wire logic dataIn, // data pin, asynchronous
  input wire logic strobeIn, // strobe pin, asynchronous
  rx_char_if.producer chan // checked characters out
);
  import link_exchange_pkg::*;

  logic dMeta_q, dSync_q, sMeta_q, sSync_q; // pin synchronisers
  logic rxClk; // recovered bit clock level
  logic rxClkPrev_q; // last recovered level
  logic edgeSeen; // a bit arrived
  logic [3:0] cnt_q; // bit index in character
  logic isCtrl_q; // current character is control
  logic parBit_q; // received parity bit
  logic [7:0] accum_q; // payload being collected
  logic accXor_q; // running xor of payload
  logic prevXor_q; // xor of previous payload
  logic pendValid_q; // completed character awaiting check
  logic pendCtrl_q; // its flag
  logic [7:0] pendData_q; // its payload
  logic [3:0] lastIdx; // index of last payload bit

  // two flip-flops before anything reads the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dMeta_q <= 1'b0;
      dSync_q <= 1'b0;
      sMeta_q <= 1'b0;
      sSync_q <= 1'b0;
    end else begin
      dMeta_q <= dataIn;
      dSync_q <= dMeta_q;
      sMeta_q <= strobeIn;
      sSync_q <= sMeta_q;
    end
  end

  assign rxClk = dSync_q ^ sSync_q;
  assign edgeSeen = enable && (rxClk != rxClkPrev_q);
  assign chan.bitEdge = edgeSeen;
  assign lastIdx = isCtrl_q ? 4'(CTRL_BITS + 1) : 4'(DATA_BITS + 1);

  // recovered clock history
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      rxClkPrev_q <= 1'b0;
    end else begin
      rxClkPrev_q <= rxClk;
    end
  end

  // bit collection and parity check, one character late
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      cnt_q <= 4'h0;
      isCtrl_q <= 1'b0;
      parBit_q <= 1'b0;
      accum_q <= 8'h00;
      accXor_q <= 1'b0;
      prevXor_q <= 1'b0;
      pendValid_q <= 1'b0;
      pendCtrl_q <= 1'b0;
      pendData_q <= 8'h00;
      chan.valid <= 1'b0;
      chan.ctrl <= 1'b0;
      chan.data <= 8'h00;
      chan.parityErr <= 1'b0;
    end else begin
      chan.valid <= 1'b0;
      chan.parityErr <= 1'b0;
      if (edgeSeen) begin
        if (cnt_q == 4'h0) begin
          parBit_q <= dSync_q;
          cnt_q <= 4'h1;
        end else if (cnt_q == 4'h1) begin
          isCtrl_q <= dSync_q;
          accum_q <= 8'h00;
          accXor_q <= 1'b0;
          cnt_q <= 4'h2;
          pendValid_q <= 1'b0;
          if (oddParity(prevXor_q, dSync_q) != parBit_q) begin
            chan.parityErr <= 1'b1; // pending character is dropped
          end else if (pendValid_q) begin
            chan.valid <= 1'b1;
            chan.ctrl <= pendCtrl_q;
            chan.data <= pendData_q;
          end
        end else begin
          accum_q[3'(cnt_q - 4'h2)] <= dSync_q;
          accXor_q <= accXor_q ^ dSync_q;
          if (cnt_q == lastIdx) begin
            pendValid_q <= 1'b1;
            pendCtrl_q <= isCtrl_q;
            pendData_q <= accum_q;
            pendData_q[3'(cnt_q - 4'h2)] <= dSync_q;
            prevXor_q <= accXor_q ^ dSync_q;
            cnt_q <= 4'h0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  end
endmodule : ds_receiver

// ===== logic/ds_transmitter.sv
// data-strobe serialiser with parity generation
`timescale 1ns/10ps
module ds_transmitter #(
  parameter int DIV = link_exchange_pkg::TX_DIV // clocks per bit
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic enable, // low holds lines at zero
  tx_char_if.consumer chan, // character offers
  output logic dataOut, // data line
  output logic strobeOut // strobe line
);
  import link_exchange_pkg::*;
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

  // refuse a divider the bit engine cannot serve
  if (DIV < 2) begin : g_bad_div
    $error("ds_transmitter: DIV must be at least 2");
  end

  logic [DW-1:0] divCnt_q; // bit period divider
  logic bitTick; // one-cycle bit enable
  logic [8:0] shift_q; // flag and payload still to send
  logic [3:0] left_q; // bits left after the current one
  logic prevXor_q; // parity share of last payload
  logic newBit; // bit leaving at this tick
  logic [8:0] loadBits; // flag first, payload lsb first
  logic loadPar; // parity of the offered character

  assign bitTick = enable && (divCnt_q == DW'(DIV - 1));
  assign chan.taken = bitTick && (left_q == 4'h0);

  // bit rate divider
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      divCnt_q <= '0;
    end else if (bitTick) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  // framing of the offered character
  always_comb begin
    loadBits = chan.ctrl ? {6'h00, chan.data[1:0], 1'b1} : {chan.data, 1'b0};
    loadPar = oddParity(prevXor_q, chan.ctrl);
    newBit = (left_q == 4'h0) ? loadPar : shift_q[0];
  end

  // character shifter, next character loaded right after the last bit
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      shift_q <= '0;
      left_q <= 4'h0;
      prevXor_q <= 1'b0; // first parity then comes out zero for a control character
    end else if (bitTick) begin
      if (left_q == 4'h0) begin
        shift_q <= loadBits;
        left_q <= chan.ctrl ? 4'(CTRL_BITS + 1) : 4'(DATA_BITS + 1);
        prevXor_q <= chan.ctrl ? ^chan.data[1:0] : ^chan.data;
      end else begin
        shift_q <= {1'b0, shift_q[8:1]};
        left_q <= left_q - 4'h1;
      end
    end
  end

  // line coding: strobe toggles when data repeats
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      dataOut <= 1'b0;
      strobeOut <= 1'b0;
    end else if (bitTick) begin
      dataOut <= newBit;
      strobeOut <= (newBit == dataOut) ? ~strobeOut : strobeOut;
    end
  end
endmodule : ds_transmitter

// ===== logic/link_exchange.sv
// exchange-level character handling and credit flow control for a ds link
`timescale 1ns/10ps
module link_exchange #(
  parameter int CREDIT_LIMIT = link_exchange_pkg::CREDIT_MAX, // credit ceiling
  parameter int BIT_DIV = link_exchange_pkg::TX_DIV // clocks per sent bit
) (
  input wire logic clk, // system clock, 250 MHz
  input wire logic rst_n, // synchronous reset, active low
  // line pins
  input wire logic dataIn, // incoming data pin
  input wire logic strobeIn, // incoming strobe pin
  output logic dataOut, // outgoing data pin
  output logic strobeOut, // outgoing strobe pin
  // link control
  input wire logic rxEnable, // receiver enabled by link control
  input wire logic txEnable, // transmitter enabled, nulls at least
  input wire logic fctAllowed, // tokens may be sent
  input wire logic ncharAllowed, // normal characters may be sent
  // host transmit
  input wire logic fctRequest, // pulse: host has room for eight more
  input wire logic txValid, // host offers a character
  input wire logic txFlag, // host character is a marker
  input wire logic [7:0] txData, // host character payload
  output logic txReady, // holding register free
  // host receive
  output logic rxValid, // pulse: character for host
  output logic rxFlag, // host character is a marker
  output logic [7:0] rxData, // host character payload
  // status
  output logic nullSeen, // pulse: null received
  output logic firstNull, // level: a null has arrived
  output logic fctSeen, // pulse: token received
  output logic [link_exchange_pkg::CREDIT_W-1:0] creditCount, // transmit credit
  output logic parityError, // pulse: parity failure
  output logic escapeError, // pulse: bad escape sequence
  output logic disconnectError, // pulse: line went silent
  output logic creditError, // pulse: token discarded, it would take credit past the ceiling
  output logic emptyPacketError // pulse: marker right after marker
);
  import link_exchange_pkg::*;
  localparam logic [CREDIT_W-1:0] LIMIT = CREDIT_W'(CREDIT_LIMIT);
  localparam logic [CREDIT_W-1:0] STEP = CREDIT_W'(CREDIT_PER_FCT);
  localparam int DCW = $clog2(DISC_CYCLES + 1);

  // refuse a ceiling below the minimum or beyond the counter
  if (CREDIT_LIMIT < CREDIT_MAX || CREDIT_LIMIT >= (1 << CREDIT_W)) begin : g_bad_limit
    $error("link_exchange: CREDIT_LIMIT out of range");
  end

  tx_char_if txc (); // offers to the serialiser
  rx_char_if rxc (); // checked characters from the line

  // receive side state
  logic escPending_q; // last received character was escape
  logic lastWasEnd_q; // last delivered character was a marker
  logic fctEvt; // token received, qualified
  logic discArmed_q; // disconnect watch running
  logic [DCW-1:0] idle_q; // cycles without a transition

  // transmit side state
  logic [FCT_PEND_W-1:0] fctPend_q; // outstanding token requests
  logic escSent_q; // escape of a null is on the wire
  logic hold_q; // host character held
  logic holdFlag_q; // its flag
  logic [7:0] holdData_q; // its payload
  logic holdLoad; // host write accepted
  logic creditInc; // token raises credit
  logic creditDec; // character spends credit
  txSel_t sel; // next character kind

  // line decoder
  ds_receiver ds_receiver_inst (
    .clk(clk),
    .rst_n(rst_n),
    .enable(rxEnable),
    .dataIn(dataIn),
    .strobeIn(strobeIn),
    .chan(rxc.producer)
  );

  // line encoder
  ds_transmitter #(.DIV(BIT_DIV)) ds_transmitter_inst (
    .clk(clk),
    .rst_n(rst_n),
    .enable(txEnable),
    .chan(txc.consumer),
    .dataOut(dataOut),
    .strobeOut(strobeOut)
  );

  // the receiver runs on clk too, so the token pulse is already in the
  // transmitter's domain: one pulse, one credit step
  assign fctEvt = rxc.valid && firstNull && !escPending_q && rxc.ctrl
    && (rxc.data[1:0] == CODE_FCT);

  // receive classification of checked characters
  always_ff @(posedge clk) begin
    if (!rst_n || !rxEnable) begin
      escPending_q <= 1'b0;
      lastWasEnd_q <= 1'b0;
      firstNull <= 1'b0;
      nullSeen <= 1'b0;
      fctSeen <= 1'b0;
      rxValid <= 1'b0;
      rxFlag <= 1'b0;
      rxData <= 8'h00;
      escapeError <= 1'b0;
      emptyPacketError <= 1'b0;
    end else begin
      // pulses last one cycle
      nullSeen <= 1'b0;
      fctSeen <= 1'b0;
      rxValid <= 1'b0;
      escapeError <= 1'b0;
      emptyPacketError <= 1'b0;
      if (rxc.valid) begin
        if (escPending_q) begin
          // second half of an escape sequence
          escPending_q <= 1'b0;
          if (rxc.ctrl && rxc.data[1:0] == CODE_FCT) begin
            nullSeen <= 1'b1;
            firstNull <= 1'b1;
          end else if (firstNull) begin
            escapeError <= 1'b1;
          end
        end else if (rxc.ctrl && rxc.data[1:0] == CODE_ESC) begin
          escPending_q <= 1'b1;
        end else if (firstNull) begin
          // before the first null everything but escapes is ignored
          if (fctEvt) begin
            fctSeen <= 1'b1;
          end else begin
            rxValid <= 1'b1;
            rxFlag <= rxc.ctrl;
            if (rxc.ctrl) begin
              rxData <= (rxc.data[1:0] == CODE_EEP) ? HOST_EEP : HOST_EOP;
              emptyPacketError <= lastWasEnd_q;
            end else begin
              rxData <= rxc.data;
            end
            lastWasEnd_q <= rxc.ctrl;
          end
        end
      end
    end
  end

  // parity failures count only once a null has been seen
  always_ff @(posedge clk) begin
    if (!rst_n || !rxEnable) begin
      parityError <= 1'b0;
    end else begin
      parityError <= rxc.parityErr && firstNull;
    end
  end

  // disconnect watch, armed by the first transition on either line
  always_ff @(posedge clk) begin
    if (!rst_n || !rxEnable) begin
      discArmed_q <= 1'b0;
      idle_q <= '0;
      disconnectError <= 1'b0;
    end else begin
      disconnectError <= 1'b0;
      if (rxc.bitEdge) begin
        discArmed_q <= 1'b1;
        idle_q <= '0;
      end else if (discArmed_q) begin
        // silence too long
        if (idle_q == DCW'(DISC_CYCLES - 1)) begin
          disconnectError <= 1'b1;
          discArmed_q <= 1'b0;
          idle_q <= '0;
        end else begin
          idle_q <= idle_q + 1'b1;
        end
      end
    end
  end

  // next character: pending token, then normal character, else null
  always_comb begin
    sel = SEL_ESC;
    if (escSent_q) begin
      sel = SEL_NULLFCT; // finish the null first
    end else if (fctAllowed && fctPend_q != '0) begin
      sel = SEL_FCT;
    end else if (ncharAllowed && hold_q && creditCount != '0) begin
      sel = SEL_NCHAR;
    end
    // default offer is a null escape
    txc.ctrl = 1'b1;
    txc.data = {6'h00, CODE_ESC};
    case (sel)
      SEL_NULLFCT, SEL_FCT: begin
        txc.data = {6'h00, CODE_FCT};
      end
      SEL_NCHAR: begin
        txc.ctrl = holdFlag_q;
        txc.data = holdFlag_q ? {6'h00, holdData_q[0] ? CODE_EEP : CODE_EOP} : holdData_q;
      end
      default: begin
        txc.data = {6'h00, CODE_ESC}; // null keeps the link alive
      end
    endcase
  end

  // null sequencing: escape is always followed by a token
  always_ff @(posedge clk) begin
    if (!rst_n || !txEnable) begin
      escSent_q <= 1'b0;
    end else if (txc.taken) begin
      escSent_q <= (sel == SEL_ESC);
    end
  end

  // outstanding token requests, one token out per request, requests beyond 15 pending are dropped
  always_ff @(posedge clk) begin
    if (!rst_n || !txEnable) begin
      fctPend_q <= '0;
    end else begin
      // request in, token out
      case ({fctRequest && fctPend_q != '1, txc.taken && sel == SEL_FCT})
        2'b10: fctPend_q <= fctPend_q + 1'b1;
        2'b01: fctPend_q <= fctPend_q - 1'b1;
        default: fctPend_q <= fctPend_q;
      endcase
    end
  end

  // host holding register, one character deep keeps packet order
  assign holdLoad = txValid && txReady;
  always_ff @(posedge clk) begin
    if (!rst_n || !txEnable) begin
      hold_q <= 1'b0;
      holdFlag_q <= 1'b0;
      holdData_q <= 8'h00;
      txReady <= 1'b0;
    end else begin
      // write and take never coincide
      if (holdLoad) begin
        hold_q <= 1'b1;
        holdFlag_q <= txFlag;
        holdData_q <= txData;
        txReady <= 1'b0;
      end else if (txc.taken && sel == SEL_NCHAR) begin
        hold_q <= 1'b0;
        txReady <= 1'b1;
      end else begin
        txReady <= !hold_q;
      end
    end
  end

  // credit count: up by eight per token, down by one per character
  assign creditInc = fctEvt && (creditCount <= LIMIT - STEP);
  assign creditDec = txc.taken && (sel == SEL_NCHAR);
  always_ff @(posedge clk) begin
    if (!rst_n || !txEnable) begin
      creditCount <= CREDIT_RESET;
      creditError <= 1'b0;
    end else begin
      creditError <= fctEvt && !creditInc; // token discarded
      // both at once nets seven
      case ({creditInc, creditDec})
        2'b10: creditCount <= creditCount + STEP;
        2'b01: creditCount <= creditCount - 1'b1;
        2'b11: creditCount <= creditCount + STEP - 1'b1;
        default: creditCount <= creditCount;
      endcase
    end
  end
endmodule : link_exchange

// ===== logic/link_exchange_pkg.sv
// shared constants, types and helpers for the link exchange block
package link_exchange_pkg;
  // clock and bit timing
  localparam int CLK_PERIOD_PS = 4000; // 250 MHz system clock
  localparam int TX_BIT_NS = 100; // start-up bit period, 10 Mbps
  localparam int TX_DIV = TX_BIT_NS * 1000 / CLK_PERIOD_PS; // clocks per sent bit
  localparam int DISC_NS = 1000; // silence that counts as disconnect
  localparam int DISC_CYCLES = DISC_NS * 1000 / CLK_PERIOD_PS; // longest time, rounds down
  // character layout
  localparam int DATA_BITS = 8; // payload bits of a data character
  localparam int CTRL_BITS = 2; // payload bits of a control character
  localparam logic [1:0] CODE_FCT = 2'h0; // flow control token
  localparam logic [1:0] CODE_EOP = 2'h1; // end of packet
  localparam logic [1:0] CODE_EEP = 2'h2; // error end of packet
  localparam logic [1:0] CODE_ESC = 2'h3; // escape
  localparam logic [7:0] HOST_EOP = 8'h00; // host coding of end of packet
  localparam logic [7:0] HOST_EEP = 8'h01; // host coding of error end of packet
  // flow control
  localparam int CREDIT_PER_FCT = 8; // characters granted per token
  localparam int CREDIT_MAX = 56; // credit ceiling
  localparam int CREDIT_W = 7; // credit counter width
  localparam int FCT_PEND_W = 4; // outstanding token request counter width
  localparam logic [CREDIT_W-1:0] CREDIT_RESET = 7'h00; // credit after reset

  // next character chosen for the wire
  typedef enum logic [1:0] {SEL_ESC, SEL_NULLFCT, SEL_FCT, SEL_NCHAR} txSel_t;

  // odd parity over previous payload bits and current flag
  function automatic logic oddParity(input logic prevXor, input logic flag);
    return ~(prevXor ^ flag);
  endfunction : oddParity
endpackage : link_exchange_pkg

// ===== verification/ds_peer_model.sv
// far-end ds link: encoder with null fill, decoder of the block's line
`timescale 1ns/10ps
module ds_peer_model (
  output logic lineData, // data to block
  output logic lineStrobe, // strobe to block
  input wire logic farData, // data from block
  input wire logic farStrobe // strobe from block
);
  import link_exchange_pkg::*;
  logic [9:0] txQ[$]; // {bad parity, flag, payload}
  logic [8:0] rxLog[$]; // decoded tokens (1FF) and normal chars
  logic run = 0; // sending on
  logic listen = 0; // decoding on
  logic px = 0; // xor of last sent payload
  logic esc = 0; // escape pending on decode
  logic fl = 0; // flag of char being decoded
  logic [7:0] sh = 8'h00; // payload collector
  int n = 0; // bit index in char
  // one bit at 125 ns, strobe toggles when data repeats
  task automatic putBit(input logic b);
    lineStrobe = (b == lineData) ? ~lineStrobe : lineStrobe;
    lineData = b;
    #125;
  endtask : putBit
  // parity, flag, payload lsb first; bad bit inverts parity
  task automatic putChar(input logic [9:0] c);
    int i;
    putBit(~(px ^ c[8]) ^ c[9]);
    putBit(c[8]);
    for (i = 0; i < (c[8] ? CTRL_BITS : DATA_BITS); i++) putBit(c[i]);
    px = c[8] ? ^c[1:0] : ^c[7:0];
  endtask : putChar
  // queued chars first, nulls otherwise, lines idle while stopped
  initial begin
    lineData = 0;
    lineStrobe = 0;
    forever begin
      if (!run) #125;
      else if (txQ.size() > 0) putChar(txQ.pop_front());
      else begin
        putChar(10'h103);
        putChar(10'h100);
      end
    end
  end
  // every change on either line is one bit
  always @(farData or farStrobe) begin
    if (!listen) n = 0;
    else if (n == 0) n = 1;
    else if (n == 1) begin
      fl = farData;
      n = 2;
    end else begin
      sh[n-2] = farData;
      n++;
      if (n == (fl ? 4 : 10)) begin
        n = 0;
        if (fl && sh[1:0] == CODE_ESC) esc = 1;
        else if (fl && sh[1:0] == CODE_FCT && esc) esc = 0; // null dropped
        else rxLog.push_back(!fl ? {1'b0, sh} : (sh[1:0] == CODE_FCT ? 9'h1FF : {8'h80, sh[1]}));
      end
    end
  end
endmodule : ds_peer_model

// ===== verification/link_exchange_assertions.sv
// port assertions for the link exchange block
`timescale 1ns/10ps
module link_exchange_assertions
  import link_exchange_pkg::*;
#(
  parameter int CREDIT_LIMIT = CREDIT_MAX // credit ceiling
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic txEnable, // tx on
  input wire logic rxEnable, // rx on
  input wire logic txValid, // host offer
  input wire logic txReady, // holding free
  input wire logic rxValid, // host char
  input wire logic rxFlag, // marker
  input wire logic [7:0] rxData, // payload
  input wire logic nullSeen, // null pulse
  input wire logic firstNull, // null level
  input wire logic fctSeen, // token pulse
  input wire logic [CREDIT_W-1:0] creditCount, // credit
  input wire logic creditError, // ceiling hit
  input wire logic parityError, // parity
  input wire logic escapeError, // escape
  input wire logic emptyPacketError // empty
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_credit_zero: assert property ($rose(rst_n) |-> creditCount == 7'h00)
    else $error("credit not zero after reset");
  a_credit_ceiling: assert property (creditCount <= CREDIT_LIMIT)
    else $error("credit above ceiling");
  a_credit_step: assert property ($changed(creditCount) && $past(txEnable) |->
    creditCount == $past(creditCount) + 7'h08 || creditCount == $past(creditCount) + 7'h07
    || creditCount + 7'h01 == $past(creditCount)) else $error("credit step wrong");
  a_credit_full: assert property (creditError |-> creditCount >= CREDIT_LIMIT - 8)
    else $error("token dropped below ceiling");
  a_credit_hold: assert property (creditError |-> creditCount <= $past(creditCount))
    else $error("credit grew on dropped token");
  a_quiet_before_null: assert property (!firstNull |->
    !(rxValid || fctSeen || parityError || escapeError || emptyPacketError)) else $error("activity before null");
  a_null_latch: assert property (nullSeen ##1 rxEnable |-> firstNull)
    else $error("null not latched");
  a_rx_pulse: assert property (rxValid |=> !rxValid)
    else $error("host char longer than a cycle");
  a_marker_code: assert property (rxValid && rxFlag |-> rxData[7:1] == 7'h00)
    else $error("marker upper bits set");
  a_write_taken: assert property (txValid && txReady |=> !txReady)
    else $error("ready stayed after write");
endmodule : link_exchange_assertions

// ===== verification/tb_link_exchange.sv
// self-checking bench for the link exchange block
`timescale 1ns/10ps
module tb_link_exchange;
  import link_exchange_pkg::*;
  localparam int CREDIT_LIMIT = CREDIT_MAX; // credit ceiling
  logic clk = 0, rst_n = 0; // clock, reset
  logic rxEnable = 0, txEnable = 0, fctAllowed = 0, ncharAllowed = 0; // link control
  logic fctRequest = 0, txValid = 0, txFlag = 0; // host strobes
  logic [7:0] txData = 8'h00; // host payload
  logic dataIn, strobeIn, dataOut, strobeOut, txReady, rxValid, rxFlag; // pins, flags
  logic [7:0] rxData; // received payload
  logic nullSeen, firstNull, fctSeen, parityError, escapeError, disconnectError, creditError, emptyPacketError;
  logic [CREDIT_W-1:0] creditCount; // credit
  logic [4:0] errSeen = 5'h00; // sticky {disc, empty, credit, escape, parity}
  logic [8:0] rxQ[$]; // chars given to host
  int fctCnt = 0, error_cnt = 0, cmp_count = 0; // counters
  always #2 clk = ~clk; // 250 MHz
  link_exchange #(.CREDIT_LIMIT(CREDIT_LIMIT), .BIT_DIV(4)) link_exchange_inst (.*);
  ds_peer_model ds_peer_model_inst (.lineData(dataIn), .lineStrobe(strobeIn), .farData(dataOut), .farStrobe(strobeOut));
  // collect host chars, tokens and error pulses
  always @(posedge clk) begin
    if (rxValid === 1'b1) rxQ.push_back({rxFlag, rxData});
    if (fctSeen === 1'b1) fctCnt++;
    errSeen <= errSeen | {disconnectError, emptyPacketError, creditError, escapeError, parityError};
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // expired wait ends the run
  task automatic bound(input logic ok);
    if (!ok) begin
      $display("MISMATCH wait expected 1 seen 0");
      error_cnt++;
      final_report();
    end
  endtask : bound
  task automatic hostWrite(input logic f, input logic [7:0] d);
    int i;
    for (i = 0; i < 5000 && txReady !== 1'b1; i++) @(negedge clk);
    bound(txReady === 1'b1);
    txValid = 1;
    txFlag = f;
    txData = d;
    @(negedge clk);
    txValid = 0;
  endtask : hostWrite
  // data before any null must be ignored
  task automatic startupTest;
    int i;
    chk("credit", creditCount, 7'h00);
    ds_peer_model_inst.txQ.push_back(10'h0AA);
    rxEnable = 1;
    txEnable = 1;
    ds_peer_model_inst.listen = 1;
    ds_peer_model_inst.run = 1;
    for (i = 0; i < 3000 && firstNull !== 1'b1; i++) @(negedge clk);
    chk("firstNull", firstNull, 1'b1);
    chk("early chars", rxQ.size(), 0);
    $display("startupTest done");
  endtask : startupTest
  // no char without credit, then tokens until one is discarded at 55
  task automatic creditTest;
    int i;
    fctAllowed = 1;
    ncharAllowed = 1;
    hostWrite(1'b0, 8'h5A);
    repeat (1500) @(negedge clk);
    chk("sent early", ds_peer_model_inst.rxLog.size(), 0);
    ds_peer_model_inst.txQ.push_back(10'h100);
    for (i = 0; i < 3000 && ds_peer_model_inst.rxLog.size() == 0; i++) @(negedge clk);
    bound(ds_peer_model_inst.rxLog.size() > 0);
    chk("first char", ds_peer_model_inst.rxLog.pop_front(), 9'h05A);
    chk("credit", creditCount, 7'h07);
    errSeen = 5'h00;
    repeat (7) ds_peer_model_inst.txQ.push_back(10'h100);
    for (i = 0; i < 8000 && errSeen[2] !== 1'b1; i++) @(negedge clk);
    chk("credit error", errSeen[2], 1'b1);
    chk("credit max", creditCount, 7'h37);
    $display("creditTest done");
  endtask : creditTest
  // three requests go out before a waiting marker
  task automatic priorityTest;
    int i;
    fctRequest = 1;
    repeat (3) @(negedge clk);
    fctRequest = 0;
    hostWrite(1'b1, HOST_EOP);
    for (i = 0; i < 5000 && ds_peer_model_inst.rxLog.size() < 4; i++) @(negedge clk);
    bound(ds_peer_model_inst.rxLog.size() >= 4);
    for (i = 0; i < 3; i++) chk("token", ds_peer_model_inst.rxLog.pop_front(), 9'h1FF);
    chk("marker", ds_peer_model_inst.rxLog.pop_front(), 9'h100);
    $display("priorityTest done");
  endtask : priorityTest
  // packet with both markers and a token
  task automatic receiveTest;
    logic [8:0] exp[4] = '{9'h0C3, 9'h100, 9'h03C, 9'h101};
    int i;
    int f0;
    rxQ.delete();
    f0 = fctCnt;
    ds_peer_model_inst.txQ = '{10'h0C3, 10'h101, 10'h03C, 10'h102, 10'h100};
    for (i = 0; i < 8000 && (rxQ.size() < 4 || fctCnt == f0); i++) @(negedge clk);
    bound(rxQ.size() >= 4);
    for (i = 0; i < 4; i++) chk("rx char", rxQ[i], exp[i]);
    chk("rx count", rxQ.size(), 4);
    chk("token seen", fctCnt - f0, 1);
    $display("receiveTest done");
  endtask : receiveTest
  // bad parity, bad escape, empty packet
  task automatic errorTest;
    int i;
    errSeen = 5'h00;
    rxQ.delete();
    ds_peer_model_inst.txQ = '{10'h077, 10'h300, 10'h103, 10'h101, 10'h101, 10'h101};
    for (i = 0; i < 9000 && (errSeen & 5'h0B) !== 5'h0B; i++) @(negedge clk);
    chk("parity", errSeen[0], 1'b1);
    chk("escape", errSeen[1], 1'b1);
    chk("empty", errSeen[3], 1'b1);
    chk("dropped", rxQ.size() > 0 && rxQ[0] == 9'h077, 1'b0);
    $display("errorTest done");
  endtask : errorTest
  task automatic disconnectTest;
    int i;
    ds_peer_model_inst.run = 0;
    errSeen = 5'h00;
    for (i = 0; i < 1000 && errSeen[4] !== 1'b1; i++) @(negedge clk);
    chk("disconnect", errSeen[4], 1'b1);
    $display("disconnectTest done");
  endtask : disconnectTest
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    startupTest();
    creditTest();
    priorityTest();
    receiveTest();
    errorTest();
    disconnectTest();
    final_report();
  end
  // hang guard
  initial begin
    #400000;
    bound(1'b0);
  end
endmodule : tb_link_exchange
bind link_exchange link_exchange_assertions #(.CREDIT_LIMIT(CREDIT_LIMIT)) link_exchange_assertions_inst (.*);
